// ### core/user_tap_defs.svh
// Purpose: constants for the user test access port bridge
// Assumes: eight-bit instruction register, sixteen-state controller
// Notes: timing is counted in clk edges, not in time units
`ifndef USER_TAP_DEFS_SVH
`define USER_TAP_DEFS_SVH

`define IR_WIDTH 8
`define IR_CAPTURE_VALUE 8'h01
`define IR_RESET_VALUE 8'h00
`define USER_CODE_FIRST 8'h10
`define USER_CODE_LAST 8'h7F
`define SYNC_STAGES 3

`endif

// ### core/user_tap_pkg.sv
// Purpose: types shared by the bridge and its controller
// Assumes: nothing beyond the defs header
// Notes: state codes left to the tools
package user_tap_pkg;

  // the sixteen controller states
  typedef enum logic [3:0] {
    TEST_LOGIC_RESET,
    RUN_TEST_IDLE,
    SELECT_DR_SCAN,
    CAPTURE_DR,
    SHIFT_DR,
    EXIT1_DR,
    PAUSE_DR,
    EXIT2_DR,
    UPDATE_DR,
    SELECT_IR_SCAN,
    CAPTURE_IR,
    SHIFT_IR,
    EXIT1_IR,
    PAUSE_IR,
    EXIT2_IR,
    UPDATE_IR
  } tap_state_type;

endpackage

// ### core/tap_link_if.sv
// Purpose: carries controller state from the controller to the bridge
// Assumes: both ends on the test clock
// Notes: state_d is the state that the next rising edge will load
`timescale 1ns/1ns
interface tap_link_if;
  import user_tap_pkg::*;
  tap_state_type state_q;
  tap_state_type state_d;

  modport controller (output state_q, output state_d);
  modport bridge (input state_q, input state_d);
endinterface

// ### core/tap_controller.sv
// Purpose: sixteen-state test access port controller
// Assumes: tms sampled on the rising test clock edge
// Notes: five tms highs always reach test logic reset, even without trst
`timescale 1ns/1ns
module tap_controller (
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  tap_link_if.controller link
);
  import user_tap_pkg::*;

  // next state from present state and tms
  // standard transition graph
  always_comb begin
    link.state_d = link.state_q;
    case (link.state_q)
      TEST_LOGIC_RESET: link.state_d = tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
      RUN_TEST_IDLE: link.state_d = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
      SELECT_DR_SCAN: link.state_d = tms ? SELECT_IR_SCAN : CAPTURE_DR;
      CAPTURE_DR: link.state_d = tms ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: link.state_d = tms ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: link.state_d = tms ? UPDATE_DR : PAUSE_DR;
      PAUSE_DR: link.state_d = tms ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: link.state_d = tms ? UPDATE_DR : SHIFT_DR;
      UPDATE_DR: link.state_d = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
      SELECT_IR_SCAN: link.state_d = tms ? TEST_LOGIC_RESET : CAPTURE_IR;
      CAPTURE_IR: link.state_d = tms ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: link.state_d = tms ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: link.state_d = tms ? UPDATE_IR : PAUSE_IR;
      PAUSE_IR: link.state_d = tms ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: link.state_d = tms ? UPDATE_IR : SHIFT_IR;
      UPDATE_IR: link.state_d = tms ? SELECT_DR_SCAN : RUN_TEST_IDLE;
      default: link.state_d = TEST_LOGIC_RESET;
    endcase
  end

  // state register, reset by trst
  // advance on rising tck
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      link.state_q <= TEST_LOGIC_RESET;
    end else begin
      link.state_q <= link.state_d;
    end
  end

endmodule // tap_controller

// ### core/user_tap_bridge.sv
// Purpose: bridge from the test access port pins to user fabric logic
// Assumes: tck from the host may stop between scans; clk runs free
// Notes: tck-side outputs serve user logic clocked by user_shift_clock;
//        sys_* outputs give the Update-IR, Update-DR and Shift-DR news safely on clk; a Test-Logic-Reset clear does not reach them
`timescale 1ns/1ns
`include "user_tap_defs.svh"
module user_tap_bridge #(
  parameter int IR_WIDTH = `IR_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_out,
  output logic tdo_oe_n,
  output logic user_serial_in,
  input wire logic user_serial_out,
  output logic user_shift_clock,
  output logic [IR_WIDTH-1:0] user_instruction_bus,
  output logic user_code_flag,
  output logic shift_dr_flag,
  output logic update_dr_flag,
  output logic capture_dr_flag,
  output logic [IR_WIDTH-1:0] sys_instruction_q,
  output logic sys_user_code_q,
  output logic sys_instruction_pulse_q,
  output logic sys_update_dr_pulse_q,
  output logic sys_shift_dr_q
);
  import user_tap_pkg::*;

  // true when the code lies in the user-defined range
  function automatic logic is_user_code(input logic [IR_WIDTH-1:0] code);
    is_user_code = (code >= IR_WIDTH'(`USER_CODE_FIRST)) &&
                   (code <= IR_WIDTH'(`USER_CODE_LAST));
  endfunction

  // three-stage synchroniser step; returns the shifted stage vector
  function automatic logic [2:0] sync_step(input logic [2:0] stages,
                                           input logic din);
    sync_step = {stages[1:0], din};
  endfunction

  tap_link_if link ();

  tap_controller controller (
    .tck(tck),
    .trst_n(trst_n),
    .tms(tms),
    .link(link)
  );

  // ---------------- test clock domain ----------------

  logic [IR_WIDTH-1:0] ir_shift_q;
  logic [IR_WIDTH-1:0] ir_hold_q;
  logic user_code_q;
  logic shift_dr_q;
  logic update_dr_q;
  logic capture_dr_q;
  logic shift_ir_q;
  logic ir_toggle_q;
  logic upd_toggle_q;
  logic ir_tdo_q;
  logic tdo_en_q;

  // pins handed straight through to the user side
  // direct tdi and tck wiring
  assign user_serial_in = tdi;
  assign user_shift_clock = tck;

  // instruction shift path: capture a fixed pattern, then shift lsb first
  // tdi feeds ir in Shift-IR
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_shift_q <= IR_WIDTH'(`IR_RESET_VALUE);
    end else if (link.state_q == CAPTURE_IR) begin
      ir_shift_q <= IR_WIDTH'(`IR_CAPTURE_VALUE);
    end else if (link.state_q == SHIFT_IR) begin
      ir_shift_q <= {tdi, ir_shift_q[IR_WIDTH-1:1]};
    end
  end

  // parallel instruction: held through every scan, moved on Update-IR and cleared on entry to Test-Logic-Reset;
  // a scan that never reaches Update-IR leaves the old code in place
  // refresh on Update-IR entry
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_hold_q <= IR_WIDTH'(`IR_RESET_VALUE);
      user_code_q <= 1'b0;
    end else if (link.state_d == UPDATE_IR) begin
      ir_hold_q <= ir_shift_q;
      user_code_q <= is_user_code(ir_shift_q);
    end else if (link.state_d == TEST_LOGIC_RESET) begin
      ir_hold_q <= IR_WIDTH'(`IR_RESET_VALUE);
      user_code_q <= 1'b0;
    end
  end

  // state flags come from flops loaded with the next state, so each one is
  // high for exactly the cycles spent in its state and never glitches
  // data register flags, plus the Shift-IR flag
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      shift_dr_q <= 1'b0;
      update_dr_q <= 1'b0;
      capture_dr_q <= 1'b0;
      shift_ir_q <= 1'b0;
    end else begin
      shift_dr_q <= (link.state_d == SHIFT_DR);
      update_dr_q <= (link.state_d == UPDATE_DR);
      capture_dr_q <= (link.state_d == CAPTURE_DR);
      shift_ir_q <= (link.state_d == SHIFT_IR);
    end
  end

  // event toggles for the system side; each flips once per event
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_toggle_q <= 1'b0;
      upd_toggle_q <= 1'b0;
    end else begin
      if (link.state_d == UPDATE_IR) begin
        ir_toggle_q <= ~ir_toggle_q;
      end
      if (link.state_d == UPDATE_DR) begin
        upd_toggle_q <= ~upd_toggle_q;
      end
    end
  end

  // ir bit and pin enable move on the falling edge, half a period ahead of
  // the host sampling on the next rising edge
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      ir_tdo_q <= 1'b0;
      tdo_en_q <= 1'b0;
    end else begin
      ir_tdo_q <= ir_shift_q[0];
      tdo_en_q <= shift_ir_q | shift_dr_q;
    end
  end

  // tdo pin: user data straight through in Shift-DR, ir bit in Shift-IR
  // user_serial_out to tdo
  assign tdo_out = shift_ir_q ? ir_tdo_q : user_serial_out;
  assign tdo_oe_n = ~tdo_en_q;

  assign user_instruction_bus = ir_hold_q;
  assign user_code_flag = user_code_q;
  assign shift_dr_flag = shift_dr_q;
  assign update_dr_flag = update_dr_q;
  assign capture_dr_flag = capture_dr_q;

  // ---------------- system clock domain ----------------

  logic [2:0] ir_sync_q;
  logic [2:0] upd_sync_q;
  logic [2:0] shf_sync_q;
  logic ir_seen_q;
  logic upd_seen_q;

  // toggles and the shift level pass three flops; first stage feeds only
  // the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_sync_q <= 3'h0;
      upd_sync_q <= 3'h0;
      shf_sync_q <= 3'h0;
    end else begin
      ir_sync_q <= sync_step(ir_sync_q, ir_toggle_q);
      upd_sync_q <= sync_step(upd_sync_q, upd_toggle_q);
      shf_sync_q <= sync_step(shf_sync_q, shift_dr_q);
    end
  end

  // new instruction counts once stages two and three agree; the held word
  // is stable then, as Update-IR cannot recur within a few tck periods
  // system copy follows Update-IR
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_seen_q <= 1'b0;
      sys_instruction_q <= IR_WIDTH'(`IR_RESET_VALUE);
      sys_user_code_q <= 1'b0;
      sys_instruction_pulse_q <= 1'b0;
    end else begin
      sys_instruction_pulse_q <= 1'b0;
      if (ir_sync_q[1] == ir_sync_q[2] && ir_sync_q[2] != ir_seen_q) begin
        ir_seen_q <= ir_sync_q[2];
        sys_instruction_q <= ir_hold_q;
        sys_user_code_q <= is_user_code(ir_hold_q);
        sys_instruction_pulse_q <= 1'b1;
      end
    end
  end

  // Update-DR lasts one tck, too short for clk to see as a level, so it
  // travels as a toggle and comes out as a one-cycle pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upd_seen_q <= 1'b0;
      sys_update_dr_pulse_q <= 1'b0;
    end else begin
      sys_update_dr_pulse_q <= 1'b0;
      if (upd_sync_q[1] == upd_sync_q[2] && upd_sync_q[2] != upd_seen_q) begin
        upd_seen_q <= upd_sync_q[2];
        sys_update_dr_pulse_q <= 1'b1;
      end
    end
  end

  // shift level on clk; holds its last agreed value while stages differ
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_shift_dr_q <= 1'b0;
    end else if (shf_sync_q[1] == shf_sync_q[2]) begin
      sys_shift_dr_q <= shf_sync_q[2];
    end
  end

endmodule // user_tap_bridge

// ### verification/user_tap_checker.sv
// Purpose: pin level checks for the user tap bridge
// Assumes: tck side reset by trst_n, clk side by rst_n
// Notes: flags are judged by tms steps, no copy of the state
`timescale 1ns/1ns
module user_tap_checker #(
  parameter int IR_WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo_out,
  input wire logic user_serial_in,
  input wire logic user_serial_out,
  input wire logic user_shift_clock,
  input wire logic [IR_WIDTH-1:0] user_instruction_bus,
  input wire logic user_code_flag,
  input wire logic shift_dr_flag,
  input wire logic update_dr_flag,
  input wire logic capture_dr_flag,
  input wire logic sys_instruction_pulse_q
);
  // staying in shift, and leaving it through exit1 to update
  sequence shift_hold;
    shift_dr_flag && !tms;
  endsequence
  sequence dr_exit;
    shift_dr_flag && tms ##1 tms;
  endsequence
  wire_pass_a: assert property (@(posedge clk) disable iff (!trst_n)
    user_serial_in == tdi && user_shift_clock == tck)
    else $error("serial pass through broken");
  tdo_pass_a: assert property (@(posedge tck) disable iff (!trst_n)
    shift_dr_flag |-> tdo_out == user_serial_out)
    else $error("tdo not user serial out in shift");
  capture_once_a: assert property (@(posedge tck) disable iff (!trst_n)
    capture_dr_flag |=> !capture_dr_flag)
    else $error("capture flag longer than one tck");
  shift_stays_a: assert property (@(posedge tck) disable iff (!trst_n)
    shift_hold |=> shift_dr_flag)
    else $error("shift flag dropped with tms low");
  update_entry_a: assert property (@(posedge tck) disable iff (!trst_n)
    dr_exit |=> update_dr_flag && !shift_dr_flag)
    else $error("update flag missing after exit");
  update_once_a: assert property (@(posedge tck) disable iff (!trst_n)
    update_dr_flag |=> !update_dr_flag)
    else $error("update flag longer than one tck");
  ir_hold_a: assert property (@(posedge tck) disable iff (!trst_n)
    !$stable(user_instruction_bus) |-> $past(tms) && !$past(shift_dr_flag))
    else $error("instruction changed outside update");
  code_range_a: assert property (@(posedge tck) disable iff (!trst_n)
    user_code_flag == (user_instruction_bus >= 16 &&
    user_instruction_bus <= 127))
    else $error("user code flag wrong");
  sys_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    sys_instruction_pulse_q |=> !sys_instruction_pulse_q)
    else $error("instruction pulse longer than one clk");
endmodule // user_tap_checker

bind user_tap_bridge user_tap_checker #(.IR_WIDTH(IR_WIDTH)) chk (
  .clk, .rst_n, .tck, .trst_n, .tms, .tdi, .tdo_out, .user_serial_in,
  .user_serial_out, .user_shift_clock, .user_instruction_bus,
  .user_code_flag, .shift_dr_flag, .update_dr_flag, .capture_dr_flag,
  .sys_instruction_pulse_q
);

// ### verification/tuning_model.sv
// Purpose: user tuning logic on the fabric side of the bridge
// Assumes: flags sampled on the rising user shift clock
// Notes: the parameter moves only on update, never mid shift
`timescale 1ns/1ns
module tuning_model (
  input wire logic user_shift_clock,
  input wire logic user_serial_in,
  input wire logic shift_dr_flag,
  input wire logic update_dr_flag,
  output logic user_serial_out,
  output logic [7:0] param_q
);
  logic [7:0] temp_q = 8'h00;
  always_ff @(posedge user_shift_clock) begin
    if (shift_dr_flag) begin
      temp_q <= {user_serial_in, temp_q[7:1]};
    end
  end
  always_ff @(posedge user_shift_clock) begin
    if (update_dr_flag) begin
      param_q <= temp_q;
    end
  end
  assign user_serial_out = temp_q[0]; // echoed back through tdo
endmodule // tuning_model

// ### verification/user_tap_bridge_tb.sv
// Purpose: self-checking bench for the user tap bridge
// Assumes: bench is the test host; tck runs only inside its step task
// Notes: tck 32 ns, clk 40 ns, no fixed phase between them
`timescale 1ns/1ns
`include "user_tap_defs.svh"
module user_tap_bridge_tb;
  typedef struct {logic [7:0] code; logic user;} row_type;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tck = 1'b0;
  logic trst_n = 1'b0;
  logic tms = 1'b1;
  logic tdi = 1'b0;
  logic tdo_out, tdo_oe_n, user_serial_in, user_serial_out;
  logic user_shift_clock, user_code_flag, shift_dr_flag, update_dr_flag;
  logic capture_dr_flag, sys_user_code_q, sys_instruction_pulse_q;
  logic sys_update_dr_pulse_q, sys_shift_dr_q;
  logic [7:0] user_instruction_bus, sys_instruction_q, param_q;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int ir_pulses = 0;
  int dr_pulses = 0;
  logic shift_seen = 1'b0;
  logic tdo_seen = 1'b0;
  logic oe_seen = 1'b1;
  logic [7:0] echo_dr = 8'h00;
  row_type rows [5] = '{'{8'h0F, 0}, '{8'h10, 1}, '{8'h7F, 1},
    '{8'h80, 0}, '{8'h5A, 1}};
  // bridge pins reach the bench host and the tuning model
  user_tap_bridge dut (.clk, .rst_n, .tck, .trst_n, .tms, .tdi, .tdo_out,
    .tdo_oe_n, .user_serial_in, .user_serial_out, .user_shift_clock,
    .user_instruction_bus, .user_code_flag, .shift_dr_flag,
    .update_dr_flag, .capture_dr_flag, .sys_instruction_q,
    .sys_user_code_q, .sys_instruction_pulse_q, .sys_update_dr_pulse_q,
    .sys_shift_dr_q);
  tuning_model user_logic (.user_shift_clock, .user_serial_in,
    .shift_dr_flag, .update_dr_flag, .user_serial_out, .param_q);
  always #20 clk = ~clk;
  // pin values as the host sees them at its sampling edge; tdo moves on
  // the falling edge, so reading it right after a step would race
  always @(posedge tck) begin
    tdo_seen <= tdo_out;
    oe_seen <= tdo_oe_n;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    // pulses last one clk, so each one is counted exactly once here
    if (sys_instruction_pulse_q) begin
      ir_pulses++;
    end
    if (sys_update_dr_pulse_q) begin
      dr_pulses++;
    end
    if (sys_shift_dr_q) begin
      shift_seen = 1'b1;
    end
    if (cycles == 3000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  // one tck period; inputs change at the falling edge
  task automatic step(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    #16 tck = 1'b1;
    #16 tck = 1'b0;
  endtask
  // full pass from idle to update and back, lsb first
  task automatic scan(input logic ir, input logic [7:0] v,
                      input logic [7:0] echo);
    step(1, 0);
    if (ir) begin
      step(1, 0);
    end
    step(0, 0);
    check(8'(capture_dr_flag), 8'(!ir));
    step(0, 0);
    check(8'(shift_dr_flag), 8'(!ir));
    for (int i = 0; i < 8; i++) begin
      step(i == 7, v[i]);
      check(8'({oe_seen, tdo_seen}), 8'({1'b0, echo[i]}));
    end
    step(1, 0);
    check(8'(update_dr_flag), 8'(!ir));
    step(0, 0);
    check(8'(oe_seen), 8'h01);
  endtask
  // tck pulses under reset keep sampled history clean
  task automatic reset_tap;
    trst_n <= 1'b0;
    step(1, 0);
    step(1, 0);
    trst_n <= 1'b1;
    step(0, 0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #7;
    reset_tap;
    check(user_instruction_bus, 8'h00);
    foreach (rows[i]) begin
      scan(1, rows[i].code, `IR_CAPTURE_VALUE);
      check(user_instruction_bus, rows[i].code);
      check(8'(user_code_flag), 8'(rows[i].user));
      repeat (8) @(posedge clk);
      check(sys_instruction_q, rows[i].code);
      check(8'(sys_user_code_q), 8'(rows[i].user));
      check(8'(ir_pulses), 8'(i + 1));
      // data follows the instruction; tdo echoes the old value
      scan(0, ~rows[i].code, echo_dr);
      echo_dr = ~rows[i].code;
      check(param_q, ~rows[i].code);
      check(user_instruction_bus, rows[i].code);
      repeat (8) @(posedge clk);
      check(8'(dr_pulses), 8'(i + 1));
    end
    check(8'({shift_seen, sys_shift_dr_q}), 8'h02);
    // five tms highs fall back to reset, tried here from Capture-DR only
    step(1, 0);
    step(0, 0);
    repeat (5) step(1, 0);
    check(user_instruction_bus, 8'h00);
    step(0, 0);
    scan(1, 8'h33, `IR_CAPTURE_VALUE);
    reset_tap;
    check(user_instruction_bus, 8'h00);
    tally_and_finish;
  end
endmodule // user_tap_bridge_tb
